// ===== common/pbt_pkg.sv
// constants, state encodings and carrier structs of the pixel block transfer engine
// assumes one 100 MHz clock; software reaches the registers over apb with 32-bit data
package pbt_pkg;
    // ****************************************
    // register map, byte offsets
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DIMS = 8'h08;
    localparam logic [7:0] OFF_PIXEL_SIZE_REGISTER = 8'h0c;
    localparam logic [7:0] OFF_FG = 8'h10;
    localparam logic [7:0] OFF_BG = 8'h14;
    localparam logic [7:0] OFF_SOURCE_START_REGISTER = 8'h18;
    localparam logic [7:0] OFF_DESTINATION_START_REGISTER = 8'h1c;
    localparam logic [7:0] OFF_SPITCH = 8'h20;
    localparam logic [7:0] OFF_DPITCH = 8'h24;
    localparam logic [7:0] OFF_RS_BASE = 8'h28;
    localparam int RS_COUNT = 5;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CB_START = 0;
    localparam int CB_OP_LO = 1;
    localparam int CB_HDIR = 4;
    localparam int CB_VDIR = 5;
    localparam int CB_TRANSP = 6;
    localparam int CB_PP_LO = 7;
    localparam int CB_WIN = 9;
    localparam int CTRL_W = 10;
    localparam int SB_BUSY = 0;
    localparam int SB_BIP = 1;
    localparam int SB_ABORT = 2;
    localparam int RS_XLEFT = 0;
    localparam int RS_YLEFT = 1;
    localparam int RS_SCUR = 2;
    localparam int RS_DCUR = 3;
    localparam int RS_POLL = 4;
    // ****************************************
    // codes, reset values and counts
    // ****************************************
    localparam logic [2:0] LINEAR_TO_LINEAR_OP = 3'h0;
    localparam logic [2:0] LINEAR_TO_XY_OP = 3'h1;
    localparam logic [2:0] XY_TO_LINEAR_OP = 3'h2;
    localparam logic [2:0] XY_TO_XY_OP = 3'h3;
    localparam logic [2:0] EXPAND_TO_XY_OP = 3'h4;
    localparam logic [2:0] EXPAND_TO_LINEAR_OP = 3'h5;
    localparam logic [1:0] PP_REPLACE = 2'h0;
    localparam logic [1:0] PP_AND = 2'h1;
    localparam logic [1:0] PP_OR = 2'h2;
    localparam logic [1:0] PP_XOR = 2'h3;
    localparam logic [4:0] PIXEL_SIZE_REGISTER_RST = 5'h01;
    localparam logic [31:0] POLL_PIXELS = 32'h00000010;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01, ST_ADJUST = 6'h02, ST_SRC = 6'h04,
        ST_DST = 6'h08, ST_WRITE = 6'h10, ST_STEP = 6'h20
    } pbt_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pbt_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pbt_apb_rsp_t;

    typedef struct packed {
        logic req;
        logic we;
        logic xy;
        logic [4:0] width;
        logic [31:0] addr;
        logic [15:0] wdata;
    } pbt_mem_req_t;

    typedef struct packed {
        pbt_state_t st;
        logic [CTRL_W-1:0] ctrl;
        logic [15:0] dx;
        logic [15:0] dy;
        logic [4:0] pixel_size_register;
        logic [15:0] fg;
        logic [15:0] bg;
        logic [31:0] source_start_register;
        logic [31:0] destination_start_register;
        logic [31:0] spitch;
        logic [31:0] dpitch;
        logic [RS_COUNT-1:0][31:0] rs;
        logic [15:0] src_pix;
        logic [15:0] res;
        logic busy;
        logic bip;
        logic aborted;
        logic intr_take;
        pbt_mem_req_t mem;
        pbt_apb_rsp_t apb;
    } pbt_regs_t;
endpackage

// ===== logic/pbt_engine.sv
// pixel block transfer sequencer with colour expansion, corner selection and resumable pause
// assumes a pixel memory port that raises mem_ack only while mem_req is high, and a cpu that
// pushes pc and status on intr_take and pulses return_from_interrupt_op_pulse after popping them
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module pbt_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire pbt_pkg::pbt_apb_req_t apb_req,
    output pbt_pkg::pbt_apb_rsp_t apb_rsp,
    output pbt_pkg::pbt_mem_req_t mem_out,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    input wire logic irq_pending,
    input wire logic return_from_interrupt_op_pulse,
    input wire logic window_violation,
    output logic intr_take,
    output logic block_in_progress_flag,
    output logic busy
);
    import pbt_pkg::*;

    pbt_regs_t r;
    pbt_regs_t n;

    // ****************************************
    // decoded controls
    // ****************************************
    logic [2:0] op;
    logic [1:0] pp;
    logic hdir;
    logic vdir;
    logic transp;
    logic win_en;
    logic src_xy;
    logic dst_xy;
    logic expand;
    logic adjust;
    logic [4:0] lg_pixel_size_register;
    logic [15:0] pix_mask;
    logic [31:0] xamt_s;
    logic [31:0] xamt_d;
    logic last_col;
    logic last_row;
    logic poll_due;

    function automatic logic [4:0] log2_size(input logic [4:0] s);
        case (s)
            5'h01: log2_size = 5'h00;
            5'h02: log2_size = 5'h01;
            5'h04: log2_size = 5'h02;
            5'h08: log2_size = 5'h03;
            default: log2_size = 5'h04;
        endcase
    endfunction

    function automatic logic [15:0] pp_apply(input logic [1:0] code, input logic [15:0] s, input logic [15:0] d);
        case (code)
            PP_AND: pp_apply = s & d;
            PP_OR: pp_apply = s | d;
            PP_XOR: pp_apply = s ^ d;
            default: pp_apply = s;
        endcase
    endfunction

    // xy addresses carry y in the upper half; halves step apart so no carry crosses
    function automatic logic [31:0] addr_step(input logic [31:0] a, input logic xy, input logic row,
                                              input logic neg, input logic [31:0] amt);
        logic [15:0] h;
        h = row ? a[31:16] : a[15:0];
        h = neg ? h - 16'h0001 : h + 16'h0001;
        if (xy) begin
            addr_step = row ? {h, a[15:0]} : {a[31:16], h};
        end else begin
            addr_step = neg ? a - amt : a + amt;
        end
    endfunction

    // default start is the lowest address, so reaching any corner only ever adds
    function automatic logic [31:0] corner(input logic [31:0] a, input logic xy, input logic h, input logic v,
                                           input logic [4:0] lg, input logic [31:0] pitch,
                                           input logic [15:0] w, input logic [15:0] ht);
        logic [15:0] wm1;
        logic [15:0] hm1;
        logic [31:0] xoff;
        logic [31:0] yoff;
        wm1 = w - 16'h0001;
        hm1 = ht - 16'h0001;
        xoff = h ? ({16'h0000, wm1} << lg) : 32'h00000000;
        yoff = v ? 32'(pitch * {16'h0000, hm1}) : 32'h00000000;
        if (xy) begin
            corner = {a[31:16] + (v ? hm1 : 16'h0000), a[15:0] + (h ? wm1 : 16'h0000)};
        end else begin
            corner = a + xoff + yoff;
        end
    endfunction

    assign op = r.ctrl[CB_OP_LO +: 3];
    assign pp = r.ctrl[CB_PP_LO +: 2];
    assign hdir = r.ctrl[CB_HDIR];
    assign vdir = r.ctrl[CB_VDIR];
    assign transp = r.ctrl[CB_TRANSP];
    assign win_en = r.ctrl[CB_WIN];
    assign src_xy = (op == XY_TO_LINEAR_OP) || (op == XY_TO_XY_OP);
    assign dst_xy = (op == LINEAR_TO_XY_OP) || (op == XY_TO_XY_OP) || (op == EXPAND_TO_XY_OP);
    assign expand = (op == EXPAND_TO_XY_OP) || (op == EXPAND_TO_LINEAR_OP);
    assign adjust = (op == LINEAR_TO_XY_OP) || (op == XY_TO_LINEAR_OP) || (op == XY_TO_XY_OP);
    assign lg_pixel_size_register = log2_size(r.pixel_size_register);
    assign pix_mask = 16'hffff >> (5'h10 - (5'h01 << lg_pixel_size_register));
    assign xamt_s = expand ? 32'h00000001 : (32'h00000001 << lg_pixel_size_register);
    assign xamt_d = 32'h00000001 << lg_pixel_size_register;
    assign last_col = r.rs[RS_XLEFT] <= 32'h00000001;
    assign last_row = r.rs[RS_YLEFT] <= 32'h00000001;
    assign poll_due = r.rs[RS_POLL] == (POLL_PIXELS - 32'h00000001);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] rd_v;
        logic hit;
        logic wr_en;
        logic start_cmd;
        logic [7:0] off;
        logic [15:0] sv;
        logic [31:0] srow;
        logic [31:0] drow;
        rd_v = 32'h00000000;
        wr_en = 1'b0;
        hit = 1'b1;
        off = apb_req.paddr;
        start_cmd = 1'b0;
        sv = 16'h0000;
        srow = 32'h00000000;
        drow = 32'h00000000;
        n = r;
        n.intr_take = 1'b0;
        n.apb.pready = 1'b0;
        n.apb.pslverr = 1'b0;
        // read data and error are prepared in the setup cycle and shown in the access cycle
        if (off == OFF_CTRL) begin
            rd_v = {22'h000000, r.ctrl};
        end else if (off == OFF_STATUS) begin
            rd_v = {29'h00000000, r.aborted, r.bip, r.busy};
        end else if (off == OFF_DIMS) begin
            rd_v = {r.dy, r.dx};
        end else if (off == OFF_PIXEL_SIZE_REGISTER) begin
            rd_v = {27'h0000000, r.pixel_size_register};
        end else if (off == OFF_FG) begin
            rd_v = {16'h0000, r.fg};
        end else if (off == OFF_BG) begin
            rd_v = {16'h0000, r.bg};
        end else if (off == OFF_SOURCE_START_REGISTER) begin
            rd_v = r.source_start_register;
        end else if (off == OFF_DESTINATION_START_REGISTER) begin
            rd_v = r.destination_start_register;
        end else if (off == OFF_SPITCH) begin
            rd_v = r.spitch;
        end else if (off == OFF_DPITCH) begin
            rd_v = r.dpitch;
        end else begin
            hit = 1'b0;
            for (int i = 0; i < RS_COUNT; i++) begin
                if (off == OFF_RS_BASE + 8'(i * 4)) begin
                    rd_v = r.rs[i];
                    hit = 1'b1;
                end
            end
        end
        if (apb_req.psel && !apb_req.penable) begin
            n.apb.pready = 1'b1;
            n.apb.prdata = rd_v;
            n.apb.pslverr = !hit;
        end
        wr_en = apb_req.psel && apb_req.penable && r.apb.pready && apb_req.pwrite && !r.apb.pslverr;
        // configuration is frozen while the engine runs; the walk owns these registers then
        if (wr_en && !r.busy) begin
            if (off == OFF_CTRL) begin
                n.ctrl = apb_req.pwdata[CTRL_W-1:0];
                n.ctrl[CB_START] = 1'b0;
                start_cmd = apb_req.pwdata[CB_START];
            end else if (off == OFF_DIMS) begin
                n.dy = apb_req.pwdata[31:16];
                n.dx = apb_req.pwdata[15:0];
            end else if (off == OFF_PIXEL_SIZE_REGISTER) begin
                n.pixel_size_register = apb_req.pwdata[4:0];
            end else if (off == OFF_FG) begin
                n.fg = apb_req.pwdata[15:0];
            end else if (off == OFF_BG) begin
                n.bg = apb_req.pwdata[15:0];
            end else if (off == OFF_SOURCE_START_REGISTER) begin
                n.source_start_register = apb_req.pwdata;
            end else if (off == OFF_DESTINATION_START_REGISTER) begin
                n.destination_start_register = apb_req.pwdata;
            end else if (off == OFF_SPITCH) begin
                n.spitch = apb_req.pwdata;
            end else if (off == OFF_DPITCH) begin
                n.dpitch = apb_req.pwdata;
            end else begin
                for (int i = 0; i < RS_COUNT; i++) begin
                    if (off == OFF_RS_BASE + 8'(i * 4)) begin
                        n.rs[i] = apb_req.pwdata;
                    end
                end
            end
        end
        // ****************************************
        // transfer sequencer
        // ****************************************
        case (r.st)
            ST_IDLE: begin
                if (start_cmd) begin
                    n.busy = 1'b1;
                    n.bip = 1'b0;
                    n.aborted = 1'b0;
                    n.st = ST_ADJUST;
                end else if (r.bip && return_from_interrupt_op_pulse) begin
                    n.bip = 1'b0;
                    n.busy = 1'b1;
                    n.st = ST_SRC;
                end
            end
            ST_ADJUST: begin
                if (r.dx == 16'h0000 || r.dy == 16'h0000) begin
                    n.busy = 1'b0;
                    n.st = ST_IDLE;
                end else begin
                    srow = adjust ? corner(r.source_start_register, src_xy, hdir, vdir, expand ? 5'h00 : lg_pixel_size_register, r.spitch, r.dx, r.dy) : r.source_start_register;
                    drow = adjust ? corner(r.destination_start_register, dst_xy, hdir, vdir, lg_pixel_size_register, r.dpitch, r.dx, r.dy) : r.destination_start_register;
                    n.source_start_register = srow;
                    n.destination_start_register = drow;
                    n.rs[RS_XLEFT] = {16'h0000, r.dx};
                    n.rs[RS_YLEFT] = {16'h0000, r.dy};
                    n.rs[RS_SCUR] = srow;
                    n.rs[RS_DCUR] = drow;
                    n.rs[RS_POLL] = 32'h00000000;
                    n.st = ST_SRC;
                end
            end
            ST_SRC: begin
                if (!r.mem.req) begin
                    n.mem.req = 1'b1;
                    n.mem.we = 1'b0;
                    n.mem.addr = r.rs[RS_SCUR];
                    n.mem.xy = src_xy;
                    n.mem.width = expand ? 5'h01 : r.pixel_size_register;
                end else if (mem_ack) begin
                    sv = expand ? ((mem_rdata[0] ? r.fg : r.bg) & pix_mask) : (mem_rdata & pix_mask);
                    n.mem.req = 1'b0;
                    n.src_pix = sv;
                    n.res = sv;
                    n.st = (pp == PP_REPLACE) ? ST_WRITE : ST_DST;
                end
            end
            ST_DST: begin
                if (!r.mem.req) begin
                    n.mem.req = 1'b1;
                    n.mem.we = 1'b0;
                    n.mem.addr = r.rs[RS_DCUR];
                    n.mem.xy = dst_xy;
                    n.mem.width = r.pixel_size_register;
                end else if (mem_ack) begin
                    n.mem.req = 1'b0;
                    n.res = pp_apply(pp, r.src_pix, mem_rdata & pix_mask);
                    n.st = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (!r.mem.req) begin
                    if (win_en && dst_xy && window_violation) begin
                        n.busy = 1'b0;
                        n.bip = 1'b0;
                        n.aborted = 1'b1;
                        n.st = ST_IDLE;
                    end else if (transp && r.res == 16'h0000) begin
                        n.st = ST_STEP;
                    end else begin
                        n.mem.req = 1'b1;
                        n.mem.we = 1'b1;
                        n.mem.addr = r.rs[RS_DCUR];
                        n.mem.xy = dst_xy;
                        n.mem.width = r.pixel_size_register;
                        n.mem.wdata = r.res;
                    end
                end else if (mem_ack) begin
                    n.mem.req = 1'b0;
                    n.mem.we = 1'b0;
                    n.st = ST_STEP;
                end
            end
            ST_STEP: begin
                n.rs[RS_POLL] = poll_due ? 32'h00000000 : r.rs[RS_POLL] + 32'h00000001;
                if (!last_col) begin
                    n.rs[RS_XLEFT] = r.rs[RS_XLEFT] - 32'h00000001;
                    n.rs[RS_SCUR] = addr_step(r.rs[RS_SCUR], src_xy, 1'b0, hdir, xamt_s);
                    n.rs[RS_DCUR] = addr_step(r.rs[RS_DCUR], dst_xy, 1'b0, hdir, xamt_d);
                end else if (!last_row) begin
                    srow = addr_step(r.source_start_register, src_xy, 1'b1, vdir, r.spitch);
                    drow = addr_step(r.destination_start_register, dst_xy, 1'b1, vdir, r.dpitch);
                    n.source_start_register = srow;
                    n.destination_start_register = drow;
                    n.rs[RS_SCUR] = srow;
                    n.rs[RS_DCUR] = drow;
                    n.rs[RS_XLEFT] = {16'h0000, r.dx};
                    n.rs[RS_YLEFT] = r.rs[RS_YLEFT] - 32'h00000001;
                end
                if (last_col && last_row) begin
                    n.busy = 1'b0;
                    n.bip = 1'b0;
                    n.st = ST_IDLE;
                end else if (poll_due && irq_pending) begin
                    n.busy = 1'b0;
                    n.bip = 1'b1;
                    n.intr_take = 1'b1;
                    n.st = ST_IDLE;
                end else begin
                    n.st = ST_SRC;
                end
            end
            default: begin
                n.st = ST_IDLE;
                n.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: ST_IDLE, pixel_size_register: PIXEL_SIZE_REGISTER_RST, default: '0};
        end else begin
            r <= n;
        end
    end

    assign apb_rsp = r.apb;
    assign mem_out = r.mem;
    assign intr_take = r.intr_take;
    assign block_in_progress_flag = r.bip;
    assign busy = r.busy;

    // a start written in the same cycle as a return wins over the resume
    function automatic logic start_pending();
        start_pending = apb_req.psel && apb_req.penable && r.apb.pready && apb_req.pwrite &&
                        apb_req.paddr == OFF_CTRL && apb_req.pwdata[CB_START];
    endfunction

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [31:0] d_cur_w;
    logic [31:0] y_left_w;
    assign d_cur_w = r.rs[RS_DCUR];
    assign y_left_w = r.rs[RS_YLEFT];

    sequence seq_src_done;
        r.st == ST_SRC && r.mem.req && mem_ack;
    endsequence
    sequence seq_pause;
        r.st == ST_STEP && !(last_col && last_row) && poll_due && irq_pending;
    endsequence

    AST_EXPAND_COLOR: assert property (seq_src_done and expand |=>
        r.src_pix == (($past(mem_rdata) & 16'h0001) != 16'h0000 ? r.fg & pix_mask : r.bg & pix_mask))
        else $error("expanded pixel does not match colour register");
    AST_SRC_BIT_READ: assert property (r.st == ST_SRC && r.mem.req && expand |->
        r.mem.width == 5'h01 && !r.mem.xy && !r.mem.we)
        else $error("expand source read is not a linear single bit");
    AST_TRANSPARENT: assert property (r.mem.req && r.mem.we && transp |-> r.mem.wdata != 16'h0000)
        else $error("transparent zero pixel was written");
    AST_ROW_FIRST: assert property (r.st == ST_STEP && !last_col |=> y_left_w == $past(y_left_w))
        else $error("row advanced before row was complete");
    AST_X_DIR: assert property (r.st == ST_STEP && !last_col && dst_xy |=>
        d_cur_w[15:0] == (hdir ? $past(d_cur_w[15:0]) - 16'h0001 : $past(d_cur_w[15:0]) + 16'h0001))
        else $error("x step in wrong direction");
    AST_Y_DIR: assert property (r.st == ST_STEP && last_col && !last_row && dst_xy |=>
        d_cur_w[31:16] == (vdir ? $past(d_cur_w[31:16]) - 16'h0001 : $past(d_cur_w[31:16]) + 16'h0001))
        else $error("y step in wrong direction");
    AST_PAUSE_FLAG: assert property (seq_pause |=> r.intr_take && r.bip && r.st == ST_IDLE ##1 !r.intr_take)
        else $error("interrupt pause did not set block flag with one pulse");
    AST_RESUME: assert property (r.st == ST_IDLE && r.bip && return_from_interrupt_op_pulse && !start_pending() |=>
        r.st == ST_SRC && r.busy && d_cur_w == $past(d_cur_w))
        else $error("resume did not continue at the stored pixel");
    AST_ABORT_CLEAR: assert property (r.st == ST_WRITE && !r.mem.req && win_en && dst_xy && window_violation |=>
        !r.bip && r.aborted && r.st == ST_IDLE && !r.mem.req)
        else $error("window abort left block flag set");
    AST_DONE: assert property (r.st == ST_STEP && last_col && last_row |=>
        r.st == ST_IDLE && !r.busy && !r.bip && !r.intr_take)
        else $error("transfer did not end after last pixel");
    AST_POLL_BOUND: assert property (r.busy |-> r.rs[RS_POLL] < POLL_PIXELS)
        else $error("poll counter overran interval");
endmodule

// ===== sim/pbt_mem_model.sv
// pixel memory model: acks each request after 0 to 3 waits taken from address bits 5:4
// assumes req is held until ack; single-bit reads return addr[0]^addr[3]
`timescale 1ns/1ps
module pbt_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire pbt_pkg::pbt_mem_req_t mem_out,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    import pbt_pkg::*;
    logic [1:0] wait_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h5a5a;
        end else if (mem_out.req && !mem_ack && wait_reg == mem_out.addr[5:4]) begin
            mem_ack <= 1'b1;
            wait_reg <= 2'h0;
            mem_rdata <= mem_out.width == 5'h01 ? {15'h0, mem_out.addr[0] ^ mem_out.addr[3]} : mem_out.addr[15:0];
        end else begin
            mem_ack <= 1'b0;
            wait_reg <= (mem_out.req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
            // released data never holds its last value
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// ===== sim/tb.sv
// bench: linear expand transfers in all corners, xy expand in two, transparency, pause and resume, window abort
// assumes pbt_engine and pbt_mem_model; writes are checked against a queue of expected pixels
`timescale 1ns/1ps
module tb;
    import pbt_pkg::*;
    logic pclk = 0, presetn = 0, irq_pending = 0, return_from_interrupt_op_pulse = 0, window_violation = 0, err;
    pbt_apb_req_t apb_req = '0;
    pbt_apb_rsp_t apb_rsp;
    pbt_mem_req_t mem_out;
    logic mem_ack, intr_take, block_in_progress_flag, busy;
    logic [15:0] mem_rdata;
    logic [31:0] rd;
    logic [47:0] q[$];
    logic [47:0] e;
    logic [1:0] pp_mode = 2'h0;
    int errors = 0, n_checks = 0;
    integer seed = 32'hb50a80c9;
    always #5 pclk = ~pclk;
    pbt_engine i_pbt_engine (.pclk, .presetn, .apb_req, .apb_rsp, .mem_out, .mem_ack, .mem_rdata, .irq_pending,
        .return_from_interrupt_op_pulse, .window_violation, .intr_take, .block_in_progress_flag, .busy);
    pbt_mem_model i_pbt_mem_model (.pclk, .presetn, .mem_out, .mem_ack, .mem_rdata);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    // each write seen on the memory port is matched with the oldest expected pixel
    always @(negedge pclk) begin
        if (presetn && mem_out.req && mem_out.we && mem_ack) begin
            e = q.size() > 0 ? q.pop_front() : '1;
            chk(mem_out.addr, e[47:16], "write address");
            chk(32'(mem_out.wdata), 32'(e[15:0]), "write pixel");
        end
    end
    task automatic run(input logic [2:0] op, input logic h, v, t, w, input logic [3:0] fg, bg, input int dx, dy,
        input logic irq);
        logic [31:0] sa, da, s, d;
        logic [3:0] px;
        logic xy;
        int xi, yi;
        // expand ops: the corner start of both arrays is loaded here, never adjusted by hardware
        xy = op == EXPAND_TO_XY_OP;
        sa = 32'h100 + (h ? dx - 1 : 0) + (v ? (dy - 1) * 32 : 0);
        da = xy ? {16'(v ? dy - 1 : 0), 16'(32'h1000 + (h ? dx - 1 : 0))}
            : 32'h1000 + (h ? (dx - 1) * 4 : 0) + (v ? (dy - 1) * 256 : 0);
        for (int j = 0; j < dy; j++) begin
            for (int i = 0; i < dx; i++) begin
                xi = h ? -i : i;
                yi = v ? -j : j;
                s = sa + xi + yi * 32;
                d = xy ? {16'(da[31:16] + yi), 16'(da[15:0] + xi)} : da + xi * 4 + yi * 256;
                // the memory model reads back the low address bits as the destination pixel
                px = s[0] ^ s[3] ? fg : bg;
                px = pp_mode == PP_AND ? px & d[3:0] : pp_mode == PP_OR ? px | d[3:0]
                    : pp_mode == PP_XOR ? px ^ d[3:0] : px;
                if (!w && !(t && px == 4'h0)) q.push_back({d, 12'h0, px});
            end
        end
        apb(1, OFF_DIMS, {16'(dy), 16'(dx)});
        apb(1, OFF_PIXEL_SIZE_REGISTER, 32'h4);
        apb(1, OFF_FG, {28'h0, fg});
        apb(1, OFF_BG, {28'h0, bg});
        apb(1, OFF_SOURCE_START_REGISTER, sa);
        apb(1, OFF_DESTINATION_START_REGISTER, da);
        apb(1, OFF_SPITCH, 32'h20);
        apb(1, OFF_DPITCH, 32'h100);
        window_violation <= w;
        apb(1, OFF_CTRL, {22'h0, w, pp_mode, t, v, h, op, 1'b1});
        if (irq) begin
            irq_pending <= 1'b1;
            for (int k = 0; k < 3000 && intr_take !== 1'b1; k++) @(negedge pclk);
            chk(q.size(), dx * dy - POLL_PIXELS, "pixels before pause");
            chk(intr_take, 1, "pause pulse");
            @(posedge pclk);
            irq_pending <= 1'b0;
            @(negedge pclk);
            chk(intr_take, 0, "pause pulse width");
            chk(block_in_progress_flag, 1, "flag on pause");
            chk(busy, 0, "busy on pause");
            // the resume registers are left untouched while paused
            @(posedge pclk);
            return_from_interrupt_op_pulse <= 1'b1;
            @(posedge pclk);
            return_from_interrupt_op_pulse <= 1'b0;
            repeat (2) @(negedge pclk);
            chk(busy, 1, "resumed");
        end
        repeat (2) @(negedge pclk);
        for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge pclk);
        chk(block_in_progress_flag, 0, "flag at end");
        chk(q.size(), 0, "writes missing");
        q.delete();
        if (w) begin
            apb(0, OFF_STATUS, 32'h0);
            chk(rd[SB_ABORT], 1, "abort status");
            window_violation <= 1'b0;
        end
        $display("test op %0d h %0d v %0d t %0d w %0d irq %0d done", op, h, v, t, w, irq);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            pp_mode = 2'(k);
            run(EXPAND_TO_LINEAR_OP, k[0], k[1], 0, 0, 4'($random(seed)), 4'($random(seed)),
                4, 3, 0);
        end
        pp_mode = PP_XOR;
        run(EXPAND_TO_LINEAR_OP, 0, 0, 1, 0, 4'hc, 4'h4, 4, 2, 0);
        pp_mode = PP_REPLACE;
        run(EXPAND_TO_LINEAR_OP, 0, 1, 1, 0, 4'($random(seed)) | 4'h1, 4'h0, 5, 2, 0);
        run(EXPAND_TO_LINEAR_OP, 1, 0, 0, 0, 4'h9, 4'h6, 8, 4, 1);
        run(EXPAND_TO_XY_OP, 1, 1, 0, 0, 4'($random(seed)), 4'($random(seed)), 3, 2, 0);
        run(EXPAND_TO_XY_OP, 0, 0, 0, 1, 4'h5, 4'ha, 2, 2, 0);
        apb(0, 8'hfc, 32'h0);
        chk(err, 1, "unmapped read");
        tally_and_finish();
    end
    initial begin
        #400000;
        errors++;
        tally_and_finish();
    end
endmodule
